/* dv/event_route_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module event_route_sva
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // bus
   input wire logic [event_route_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [event_route_pkg::BE_W-1:0] byteenable,
   input wire logic [event_route_pkg::DATA_W-1:0] writedata,
   input wire logic [event_route_pkg::DATA_W-1:0] readdata,
   input wire logic waitrequest,
   input wire logic write_guard_on,
   // channels
   input wire logic [event_route_pkg::NUM_CH-1:0] chan_event,
   input wire logic [event_route_pkg::NUM_CH-1:0] gclk_req,
   input wire logic [event_route_pkg::NUM_CH-1:0] chan_async
);
   import event_route_pkg::*;
   logic wdone;
   logic rdone;
   assign wdone = write && !waitrequest && !write_guard_on;
   assign rdone = read && !waitrequest;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b || !clk_en);
   // ----
   // checks
   // ----
   AST_ANSWER: assert property ($rose(read || write) |-> waitrequest [*2] ##1 !waitrequest)
      else $error("bus answer timing wrong");
   AST_CTRL_RSV: assert property (rdone && address == OFS_CONTROL |-> readdata[31:5] == 27'h0 && readdata[3:0] == 4'h0)
      else $error("control reserved bits set");
   AST_ROUTE_RSV: assert property (rdone && address == OFS_ROUTE |-> (readdata & 32'hF0C0FFF8) == 32'h0)
      else $error("route reserved bits set");
   AST_UNMAPPED: assert property (rdone && address != OFS_CONTROL
      && address != OFS_ROUTE |-> readdata == READ_UNMAPPED)
      else $error("unmapped read not zero");
   AST_NO_ASYNC_CLK: assert property ((gclk_req & chan_async) == 6'h00)
      else $error("async channel requests clock");
   AST_ON_DEMAND: assert property (wdone && address == OFS_CONTROL && byteenable[0]
      && writedata[4] && !writedata[0] |-> ##[0:3] gclk_req == ~chan_async)
      else $error("clocks not held on");
   AST_SOFT_RESET: assert property (wdone && address == OFS_CONTROL && byteenable[0]
      && writedata[0] |-> ##[1:3] (gclk_req | chan_async) == 6'h00)
      else $error("soft reset did not clear");
   AST_SOFT_EVENT: assert property (wdone && address == OFS_ROUTE
      && byteenable[1:0] == 2'h3 && writedata[8] && writedata[2:0] < 3'h6
      |-> ##[0:2] chan_event != 6'h00)
      else $error("soft event missing");
   CV_READ: cover property (rdone && address == OFS_ROUTE);
   CV_EVENT: cover property (chan_event != 6'h00);
   CV_ASYNC: cover property (chan_async != 6'h00);
endmodule : event_route_sva
bind event_route_config_regs event_route_sva chk (.sys_clk, .rst_b, .clk_en, .address, .read,
   .write, .byteenable, .writedata, .readdata, .waitrequest, .write_guard_on, .chan_event,
   .gclk_req, .chan_async);
`default_nettype wire

/* dv/tb_event_route_config_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_event_route_config_regs;
   import event_route_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic [ADDR_W-1:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [BE_W-1:0] byteenable = 4'h0;
   logic [DATA_W-1:0] writedata = 32'h0;
   logic [DATA_W-1:0] readdata;
   logic waitrequest;
   logic write_guard_on = 1'b0;
   logic [NUM_GEN-1:0] gen_level = 64'h0;
   logic [NUM_CH-1:0] chan_event;
   logic [NUM_CH-1:0] gclk_req;
   logic [NUM_CH-1:0] chan_async;
   logic [DATA_W-1:0] rd;
   logic [NUM_CH-1:0] seen = 6'h00;
   int fails = 0;
   int tests_run = 0;
   event_route_config_regs dut (.sys_clk, .rst_b, .clk_en, .address, .read, .write,
      .byteenable, .writedata, .readdata, .waitrequest, .write_guard_on, .gen_level,
      .chan_event, .gclk_req, .chan_async);
   initial forever #10 sys_clk = ~sys_clk;
   // ----
   // helpers
   // ----
   task automatic wrap_up;
      if (fails == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   task automatic check(input string what, input logic [DATA_W-1:0] got,
         input logic [DATA_W-1:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [BE_W-1:0] be,
         input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      read <= !wr;
      write <= wr;
      address <= a;
      byteenable <= be;
      writedata <= d;
      do
      begin
         @(posedge sys_clk);
         seen |= chan_event;
         n++;
      end
      while (waitrequest !== 1'b0 && n < 50);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge sys_clk);
      seen |= chan_event;
      if (n >= 50)
      begin
         check("bus timeout", 32'h1, 32'h0);
         wrap_up();
      end
   endtask : bus
   task automatic ev(input logic [NUM_CH-1:0] exp);
      repeat (6)
      begin
         @(posedge sys_clk);
         seen |= chan_event;
      end
      check("event", seen, exp);
      seen = 6'h00;
   endtask : ev
   task automatic rd_ch(input logic [2:0] ch, input logic [DATA_W-1:0] exp);
      bus(1'b1, OFS_ROUTE, 4'h1, {29'h0, ch});
      bus(1'b0, OFS_ROUTE, 4'hF, 32'h0);
      check("route", rd, exp);
   endtask : rd_ch
   // ----
   // scenarios
   // ----
   task automatic t_config;
      bus(1'b0, OFS_CONTROL, 4'hF, 32'h0);
      check("control", rd, RESET_WORD);
      check("gclk", gclk_req, 6'h00);
      bus(1'b1, OFS_ROUTE, 4'hF, 32'hF5D3FEF2);
      rd_ch(3'h2, 32'h05130002);
      bus(1'b1, OFS_ROUTE, 4'h4, 32'h00250000);
      rd_ch(3'h2, 32'h05250002);
      rd_ch(3'h3, 32'h00000003);
      for (int p = 0; p < 3; p++)
      begin
         bus(1'b1, OFS_ROUTE, 4'hF, {6'h00, p[1:0], 24'h000004});
         check("async", chan_async, (p == 2) ? 6'h10 : 6'h00);
      end
   endtask : t_config
   task automatic t_ctrl;
      bus(1'b1, OFS_CONTROL, 4'h1, 32'h000000FE);
      bus(1'b0, OFS_CONTROL, 4'hF, 32'h0);
      check("control", rd, 32'h00000010);
      check("gclk", gclk_req, 6'h2F);
      write_guard_on <= 1'b1;
      bus(1'b1, OFS_CONTROL, 4'h1, 32'h0);
      bus(1'b0, OFS_CONTROL, 4'hF, 32'h0);
      write_guard_on <= 1'b0;
      check("guard", rd, 32'h00000010);
      bus(1'b0, 4'h8, 4'hF, 32'h0);
      check("unmapped", rd, READ_UNMAPPED);
   endtask : t_ctrl
   task automatic t_events;
      bus(1'b1, OFS_ROUTE, 4'h3, 32'h00000102);
      ev(6'h04);
      rd_ch(3'h2, 32'h05250002);
      for (int e = 0; e < 4; e++)
      begin
         bus(1'b1, OFS_ROUTE, 4'hF, {4'h0, e[1:0], 2'h1, 8'h25, 16'h0002});
         gen_level[6'h25] <= 1'b1;
         ev(e[0] ? 6'h04 : 6'h00);
         gen_level[6'h25] <= 1'b0;
         ev(e[1] ? 6'h04 : 6'h00);
      end
      bus(1'b1, OFS_ROUTE, 4'hF, 32'h0D1A0002);
      gen_level[6'h1A] <= 1'b1;
      ev(6'h00);
   endtask : t_events
   task automatic t_soft_reset_bit;
      bus(1'b1, OFS_CONTROL, 4'h1, 32'h00000011);
      bus(1'b0, OFS_CONTROL, 4'hF, 32'h0);
      check("control", rd, RESET_WORD);
      check("gclk", gclk_req | chan_async, 6'h00);
      rd_ch(3'h2, 32'h00000002);
   endtask : t_soft_reset_bit
   initial
   begin
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      t_config();
      t_ctrl();
      t_events();
      t_soft_reset_bit();
      wrap_up();
   end
endmodule : tb_event_route_config_regs
`default_nettype wire

/* hdl/chan_cfg_bank.sv */
`timescale 1ns/1ns
`default_nettype none
module chan_cfg_bank
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic soft_clear,
   // configuration access
   chan_cfg_if.bank cf
);
   import event_route_pkg::*;
   chan_cfg_s store [NUM_CH];
   // ----------------------------------------
   // per-channel storage
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < NUM_CH; i++)
            store[i] <= '0;
      end
      else if (clk_en)
      begin
         if (soft_clear)
         begin
            for (int i = 0; i < NUM_CH; i++)
               store[i] <= '0;
         end
         else if (cf.wr && cf.sel < 3'(NUM_CH))
            store[cf.sel] <= cf.wdata;
      end
   end
   always_comb
   begin
      cf.rdata = (cf.sel < 3'(NUM_CH)) ? store[cf.sel] : '0;
      for (int i = 0; i < NUM_CH; i++)
         cf.cfg[i] = store[i];
   end
endmodule : chan_cfg_bank
`default_nettype wire

/* hdl/chan_cfg_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface chan_cfg_if;
   import event_route_pkg::*;
   logic wr;
   logic [2:0] sel;
   chan_cfg_s wdata;
   chan_cfg_s rdata;
   chan_cfg_s cfg [NUM_CH];
   modport bank (input wr, input sel, input wdata, output rdata, output cfg);
   modport ctl (output wr, output sel, output wdata, input rdata, input cfg);
endinterface : chan_cfg_if
`default_nettype wire

/* hdl/chan_edge_detect.sv */
`timescale 1ns/1ns
`default_nettype none
module chan_edge_detect
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic soft_clear,
   // channel
   input wire logic [1:0] edge_sel,
   input wire logic [1:0] path,
   input wire logic level,
   output logic detect
);
   import event_route_pkg::*;
   logic level_q;
   // ----------------------------------------
   // edge detection
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         level_q <= 1'b0;
      else if (clk_en)
         level_q <= soft_clear ? 1'b0 : level;
   end
   always_comb
   begin
      detect = 1'b0;
      if (path != PATH_ASYNC)
      begin
         case (edge_sel)
            EDGE_RISE: detect = level & ~level_q;
            EDGE_FALL: detect = ~level & level_q;
            EDGE_BOTH: detect = level ^ level_q;
            default: detect = 1'b0;
         endcase
      end
   end
endmodule : chan_edge_detect
`default_nettype wire

/* hdl/event_route_config_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module event_route_config_regs
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // avalon-mm slave
   input wire logic [event_route_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [event_route_pkg::BE_W-1:0] byteenable,
   input wire logic [event_route_pkg::DATA_W-1:0] writedata,
   output logic [event_route_pkg::DATA_W-1:0] readdata,
   output logic waitrequest,
   // protection
   input wire logic write_guard_on,
   // generators
   input wire logic [event_route_pkg::NUM_GEN-1:0] gen_level,
   // channel outputs
   output logic [event_route_pkg::NUM_CH-1:0] chan_event,
   output logic [event_route_pkg::NUM_CH-1:0] gclk_req,
   output logic [event_route_pkg::NUM_CH-1:0] chan_async
);
   import event_route_pkg::*;

   function automatic logic gen_valid(input logic [GEN_W-1:0] g);
      gen_valid = 1'b1;
      if (g == GEN_NONE)
         gen_valid = 1'b0;
      else if (g > GEN_LAST)
         gen_valid = 1'b0;
      else if (g >= GEN_RSV_LO && g <= GEN_RSV_HI)
         gen_valid = 1'b0;
   endfunction : gen_valid

   function automatic logic ctl_byte_hit(input logic [ADDR_W-1:0] a, input logic [BE_W-1:0] be);
      ctl_byte_hit = (a == OFS_CONTROL) && be[BYTE_SEL];
   endfunction : ctl_byte_hit

   function automatic logic route_hit(input logic [ADDR_W-1:0] a);
      route_hit = (a == OFS_ROUTE);
   endfunction : route_hit

   function automatic logic is_async(input logic [1:0] p);
      is_async = (p == PATH_ASYNC);
   endfunction : is_async

   chan_cfg_if cf ();
   bus_state_e state;
   logic clock_on_demand_ctl;
   logic [2:0] sel;
   logic soft_clear;
   logic take_wr;
   logic [NUM_GEN-1:0] gen_s1;
   logic [NUM_GEN-1:0] gen_s2;
   logic [NUM_CH-1:0] detect;
   logic [NUM_CH-1:0] chan_level;
   logic [DATA_W-1:0] next_readdata;
   logic [2:0] next_sel;
   chan_cfg_s next_cfg;
   logic ctl_wr;
   logic route_wr;
   logic inject_wr;
   logic take_rd;
   logic [NUM_CH-1:0] next_chan_event;
   logic [NUM_CH-1:0] next_gclk_req;
   logic [NUM_CH-1:0] next_chan_async;

   // ----------------------------------------
   // bus handshake: two wait cycles, answer in third
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         state <= BUS_IDLE;
      else if (clk_en)
      begin
         case (state)
            BUS_IDLE: state <= (read || write) ? BUS_ACT : BUS_IDLE;
            BUS_ACT: state <= BUS_DONE;
            BUS_DONE: state <= BUS_IDLE;
            default: state <= BUS_IDLE;
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         waitrequest <= 1'b1;
      else if (clk_en)
      begin
         if (state == BUS_ACT)
            waitrequest <= 1'b0;
         else
            waitrequest <= 1'b1;
      end
   end
   assign take_wr = clk_en && state == BUS_ACT && write && !write_guard_on;

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   assign ctl_wr = take_wr && ctl_byte_hit(address, byteenable);
   assign route_wr = take_wr && route_hit(address);
   assign inject_wr = route_wr && byteenable[BYTE_INJ] && writedata[RC_INJECT_BIT];
   assign soft_clear = ctl_wr && writedata[CTL_SOFT_RESET_BIT];
   always_comb
   begin
      next_sel = sel;
      next_cfg = cf.rdata;
      if (address == OFS_ROUTE && byteenable[BYTE_SEL])
         next_sel = writedata[RC_SEL_HI:RC_SEL_LO];
      if (byteenable[BYTE_GEN])
         next_cfg.gen = writedata[RC_GEN_HI:RC_GEN_LO];
      if (byteenable[BYTE_PE])
      begin
         next_cfg.path = writedata[RC_PATH_HI:RC_PATH_LO];
         next_cfg.edge_sel = writedata[RC_EDGE_HI:RC_EDGE_LO];
      end
   end
   // ----------------------------------------
   // control register
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         clock_on_demand_ctl <= 1'b0;
      else if (clk_en)
      begin
         if (soft_clear)
            clock_on_demand_ctl <= 1'b0;
         else if (ctl_wr)
            clock_on_demand_ctl <= writedata[CTL_CLOCK_ON_DEMAND_BIT];
      end
   end

   // ----------------------------------------
   // channel selection
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         sel <= SEL_RESET;
      else if (clk_en)
      begin
         if (soft_clear)
            sel <= SEL_RESET;
         else if (route_wr)
            sel <= next_sel;
      end
   end

   // ----------------------------------------
   // bank access
   // ----------------------------------------
   assign cf.sel = route_wr ? next_sel : sel;
   assign cf.wr = route_wr && (byteenable[BYTE_GEN] || byteenable[BYTE_PE]);
   assign cf.wdata = next_cfg;

   chan_cfg_bank u_bank
   (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .soft_clear(soft_clear),
      .cf(cf)
   );

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_comb
   begin
      next_readdata = READ_UNMAPPED;
      if (address == OFS_CONTROL)
         next_readdata[CTL_CLOCK_ON_DEMAND_BIT] = clock_on_demand_ctl;
      else if (address == OFS_ROUTE)
      begin
         next_readdata[RC_SEL_HI:RC_SEL_LO] = sel;
         next_readdata[RC_GEN_HI:RC_GEN_LO] = cf.rdata.gen;
         next_readdata[RC_PATH_HI:RC_PATH_LO] = cf.rdata.path;
         next_readdata[RC_EDGE_HI:RC_EDGE_LO] = cf.rdata.edge_sel;
      end
   end
   assign take_rd = state == BUS_IDLE && read;

   // ----------------------------------------
   // read register
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         readdata <= RESET_WORD;
      else if (clk_en && take_rd)
         readdata <= next_readdata;
   end

   // ----------------------------------------
   // generator synchronisers and channel logic
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         gen_s1 <= '0;
      else if (clk_en)
         gen_s1 <= gen_level;
   end
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         gen_s2 <= '0;
      else if (clk_en)
         gen_s2 <= gen_s1;
   end

   // ----------------------------------------
   // per-channel edge detection
   // ----------------------------------------
   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++)
      begin : g_ch
         assign chan_level[c] = gen_valid(cf.cfg[c].gen) && gen_s2[cf.cfg[c].gen];
         chan_edge_detect u_edge
         (
            .sys_clk(sys_clk),
            .rst_b(rst_b),
            .clk_en(clk_en),
            .soft_clear(soft_clear),
            .edge_sel(cf.cfg[c].edge_sel),
            .path(cf.cfg[c].path),
            .level(chan_level[c]),
            .detect(detect[c])
         );
      end
   endgenerate
   // ----------------------------------------
   // next channel outputs
   // ----------------------------------------
   always_comb
   begin
      next_chan_event = '0;
      next_gclk_req = '0;
      next_chan_async = '0;
      if (!soft_clear)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            next_chan_event[i] = detect[i] || (inject_wr && next_sel == 3'(i));
            next_chan_async[i] = is_async(cf.cfg[i].path);
            next_gclk_req[i] = !is_async(cf.cfg[i].path)
               && (clock_on_demand_ctl || detect[i]);
         end
      end
   end

   // ----------------------------------------
   // registered channel outputs
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         chan_event <= '0;
      else if (clk_en)
         chan_event <= next_chan_event;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         gclk_req <= '0;
      else if (clk_en)
         gclk_req <= next_gclk_req;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         chan_async <= '0;
      else if (clk_en)
         chan_async <= next_chan_async;
   end
endmodule : event_route_config_regs
`default_nettype wire

/* hdl/event_route_pkg.sv */
package event_route_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int NUM_CH = 6;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int GEN_W = 6;
   localparam int NUM_GEN = 64;
   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_ROUTE = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_WORD_MASK = 4'hC;
   // ----------------------------------------
   // control fields
   // ----------------------------------------
   localparam int CTL_SOFT_RESET_BIT = 0;
   localparam int CTL_CLOCK_ON_DEMAND_BIT = 4;
   // ----------------------------------------
   // route_config fields
   // ----------------------------------------
   localparam int RC_SEL_LO = 0;
   localparam int RC_SEL_HI = 2;
   localparam int RC_INJECT_BIT = 8;
   localparam int RC_GEN_LO = 16;
   localparam int RC_GEN_HI = 21;
   localparam int RC_PATH_LO = 24;
   localparam int RC_PATH_HI = 25;
   localparam int RC_EDGE_LO = 26;
   localparam int RC_EDGE_HI = 27;
   localparam int BYTE_SEL = 0;
   localparam int BYTE_INJ = 1;
   localparam int BYTE_GEN = 2;
   localparam int BYTE_PE = 3;
   // ----------------------------------------
   // codes and reset values
   // ----------------------------------------
   localparam logic [1:0] PATH_SYNC = 2'h0;
   localparam logic [1:0] PATH_RESYNC = 2'h1;
   localparam logic [1:0] PATH_ASYNC = 2'h2;
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [GEN_W-1:0] GEN_NONE = 6'h00;
   localparam logic [GEN_W-1:0] GEN_LAST = 6'h26;
   localparam logic [GEN_W-1:0] GEN_RSV_LO = 6'h18;
   localparam logic [GEN_W-1:0] GEN_RSV_HI = 6'h1E;
   localparam logic [DATA_W-1:0] RESET_WORD = 32'h00000000;
   localparam logic [2:0] SEL_RESET = 3'h0;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h00000000;
   typedef enum logic [2:0]
   {
      BUS_IDLE = 3'b001,
      BUS_ACT = 3'b010,
      BUS_DONE = 3'b100
   } bus_state_e;
   typedef struct packed
   {
      logic [1:0] edge_sel;
      logic [1:0] path;
      logic [GEN_W-1:0] gen;
   } chan_cfg_s;
endpackage : event_route_pkg
